// file: hdl/ioexp_top.sv
// What this block does
// (RULE1) Two eight-line ports with four registers each
// (RULE2) All lines are inputs after reset
// (RULE3) Direction bit per line chooses input or output
// (RULE4) Input register samples pins; outputs follow register
// (RULE5) Polarity bit inverts input value read back
// (RULE6) Master can read every device register
// (RULE7) Interrupt while input differs from held value
// (RULE8) Interrupt pin open-drain, pulls low when active
// (RULE9) Reset loads defaults, bus machine goes idle
// (RULE10) Three strap pins give sixty-four addresses
// (RULE11) Works at 100 kHz, 400 kHz, 1 MHz
// (RULE12) Spikes filtered on serial clock and data
// (RULE13) Open-drain variant only pulls low for zero
// (RULE14) Command byte selects register; input read clears interrupt
// (RULE15) Acknowledge only the strapped seven-bit address
//
// Top of the two-wire I/O expander with an Avalon-MM side channel.
// Assumes SCL, SDA, straps and port pins synchronous to CORE_CLK.
`default_nettype none
`include "ioexp_params.svh"
module ioexp_top
   import ioexp_pkg::*;
#(
   parameter int W = `IOEXP_PORT_W,
   parameter bit OPEN_DRAIN = 1'b0,
   parameter int FILT_CYC = `IOEXP_FILT_CYC
) (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE_N,
   input wire logic ADDR_SELECT_0,
   input wire logic ADDR_SELECT_1,
   input wire logic ADDR_SELECT_2,
   input wire logic [W-1:0] PORT_A_I,
   output logic [W-1:0] PORT_A_O,
   output logic [W-1:0] PORT_A_OE_N,
   input wire logic [W-1:0] PORT_B_I,
   output logic [W-1:0] PORT_B_O,
   output logic [W-1:0] PORT_B_OE_N,
   output logic INT_N_O,
   output logic INT_N_OE_N,
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output logic IRQ
);
   // Filtered serial and strap lines
   logic [4:0] filt;
   logic scl_f;
   logic sda_f;
   logic [2:0] strap_f;

   ioexp_filt #(.W(5), .CYC(FILT_CYC)) u_filt (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .raw({ADDR_SELECT_2, ADDR_SELECT_1, ADDR_SELECT_0, SDA_I, SCL_I}), // RULE12
      .filt(filt)
   );

   assign scl_f = filt[0];
   assign sda_f = filt[1];
   assign strap_f = filt[4:2];

   logic scl_prev_q;
   logic sda_prev_q;
   logic [2:0] strap_prev_q;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   assign scl_rise = scl_f && !scl_prev_q; // RULE11
   assign scl_fall = !scl_f && scl_prev_q;
   assign bus_start = scl_f && scl_prev_q && sda_prev_q && !sda_f;
   assign bus_stop = scl_f && scl_prev_q && !sda_prev_q && sda_f;

   // Bus state
   ioexp_state_e state_q;
   ioexp_state_e state_d;
   logic [7:0] shreg_q;
   logic [3:0] cnt_q;
   logic [2:0] cmd_q;
   logic rw_q;
   logic nack_q;
   logic sda_low_q;
   logic [2:0] strap_pre_q;
   logic [2:0] strap_st_q;
   logic [2:0] strap_low_q;
   logic need_low_q;
   logic ctrl_en_q;

   // Own address from strap codes
   logic [6:0] my_addr;
   assign my_addr = {`IOEXP_ADDR_BASE,
                     ioexp_code(strap_pre_q[2], strap_st_q[2], strap_low_q[2]),
                     ioexp_code(strap_pre_q[1], strap_st_q[1], strap_low_q[1]),
                     ioexp_code(strap_pre_q[0], strap_st_q[0], strap_low_q[0])}; // RULE10

   logic byte_done;
   logic addr_hit;
   logic wr_strobe;
   logic load_rd;
   logic [2:0] rd_sel;
   assign byte_done = scl_fall && (cnt_q == `IOEXP_BIT_LAST);
   assign addr_hit = ctrl_en_q && (shreg_q[7:1] == my_addr); // RULE15
   assign wr_strobe = (state_q == ST_WR) && byte_done;
   assign load_rd = scl_fall && (((state_q == ST_ACKA) && rw_q)
                                 || ((state_q == ST_RACK) && !nack_q));
   assign rd_sel = (state_q == ST_RACK) ? (cmd_q ^ 3'h1) : cmd_q;

   // Port register banks
   logic [W-1:0] out_a, pol_a, cfg_a, rdv_a;
   logic [W-1:0] out_b, pol_b, cfg_b, rdv_b;
   logic chg_a;
   logic chg_b;

   ioexp_port #(.W(W), .OPEN_DRAIN(OPEN_DRAIN)) u_port_a ( // RULE1
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .pin_i(PORT_A_I),
      .wdata(shreg_q[W-1:0]),
      .wr_out(wr_strobe && cmd_q == `IOEXP_CMD_OUT_A),
      .wr_pol(wr_strobe && cmd_q == `IOEXP_CMD_POL_A),
      .wr_cfg(wr_strobe && cmd_q == `IOEXP_CMD_CFG_A),
      .snap_ld(load_rd && rd_sel == `IOEXP_CMD_IN_A),
      .out_val(out_a),
      .pol_val(pol_a),
      .cfg_val(cfg_a),
      .rd_val(rdv_a),
      .pin_o(PORT_A_O),
      .pin_oe_n(PORT_A_OE_N),
      .changed(chg_a)
   );

   ioexp_port #(.W(W), .OPEN_DRAIN(OPEN_DRAIN)) u_port_b ( // RULE1
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .pin_i(PORT_B_I),
      .wdata(shreg_q[W-1:0]),
      .wr_out(wr_strobe && cmd_q == `IOEXP_CMD_OUT_B),
      .wr_pol(wr_strobe && cmd_q == `IOEXP_CMD_POL_B),
      .wr_cfg(wr_strobe && cmd_q == `IOEXP_CMD_CFG_B),
      .snap_ld(load_rd && rd_sel == `IOEXP_CMD_IN_B),
      .out_val(out_b),
      .pol_val(pol_b),
      .cfg_val(cfg_b),
      .rd_val(rdv_b),
      .pin_o(PORT_B_O),
      .pin_oe_n(PORT_B_OE_N),
      .changed(chg_b)
   );

   // Read mux over all eight registers
   logic [7:0] rd_byte;
   always_comb begin
      unique case (rd_sel)
         `IOEXP_CMD_IN_A: rd_byte = 8'(rdv_a);
         `IOEXP_CMD_IN_B: rd_byte = 8'(rdv_b);
         `IOEXP_CMD_OUT_A: rd_byte = 8'(out_a);
         `IOEXP_CMD_OUT_B: rd_byte = 8'(out_b);
         `IOEXP_CMD_POL_A: rd_byte = 8'(pol_a);
         `IOEXP_CMD_POL_B: rd_byte = 8'(pol_b);
         `IOEXP_CMD_CFG_A: rd_byte = 8'(cfg_a);
         `IOEXP_CMD_CFG_B: rd_byte = 8'(cfg_b);
      endcase
   end // RULE6

   // Next bus state
   always_comb begin
      state_d = state_q;
      if (bus_start) begin
         state_d = ST_ADDR;
      end else if (bus_stop) begin
         state_d = ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: state_d = ST_IDLE;
            ST_ADDR: if (byte_done) state_d = addr_hit ? ST_ACKA : ST_IDLE; // RULE15
            ST_ACKA: if (scl_fall) state_d = rw_q ? ST_RD : ST_CMD;
            ST_CMD: if (byte_done) state_d = ST_ACKC; // RULE14
            ST_ACKC: if (scl_fall) state_d = ST_WR;
            ST_WR: if (byte_done) state_d = ST_ACKC;
            ST_RD: if (scl_fall && cnt_q == `IOEXP_BIT_LAST - 4'h1) state_d = ST_RACK;
            ST_RACK: if (scl_fall) state_d = nack_q ? ST_IDLE : ST_RD;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         state_q <= ST_IDLE; // RULE9
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
         strap_prev_q <= 3'h0;
      end else begin
         state_q <= state_d;
         scl_prev_q <= scl_f;
         sda_prev_q <= sda_f;
         strap_prev_q <= strap_f;
      end
   end

   // Strap capture: before start, at start, first clock low
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         strap_pre_q <= 3'h0;
         strap_st_q <= 3'h0;
         strap_low_q <= 3'h0;
         need_low_q <= 1'b0;
      end else if (bus_start) begin
         strap_pre_q <= strap_prev_q; // RULE10
         strap_st_q <= strap_f;
         need_low_q <= 1'b1;
      end else if (need_low_q && scl_fall) begin
         strap_low_q <= strap_f;
         need_low_q <= 1'b0;
      end
   end

   // Shifter, bit count, command pointer and data line
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         shreg_q <= 8'h00;
         cnt_q <= 4'h0;
         cmd_q <= `IOEXP_CMD_IN_A;
         rw_q <= 1'b0;
         nack_q <= 1'b0;
         sda_low_q <= 1'b0;
      end else if (bus_start || bus_stop) begin
         cnt_q <= 4'h0;
         sda_low_q <= 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: sda_low_q <= 1'b0;
            ST_ADDR, ST_CMD, ST_WR: begin
               if (scl_rise) begin
                  shreg_q <= {shreg_q[6:0], sda_f};
                  cnt_q <= cnt_q + 4'h1;
               end
               if (byte_done) begin
                  cnt_q <= 4'h0;
                  sda_low_q <= (state_q != ST_ADDR) || addr_hit;
                  if (state_q == ST_ADDR) rw_q <= shreg_q[0];
                  if (state_q == ST_CMD) cmd_q <= shreg_q[2:0]; // RULE14
                  // Successive writes alternate within the register pair
                  if (state_q == ST_WR) cmd_q <= cmd_q ^ 3'h1;
               end
            end
            ST_ACKA, ST_ACKC: begin
               if (scl_fall) begin
                  sda_low_q <= 1'b0;
                  if (load_rd) begin
                     shreg_q <= rd_byte;
                     sda_low_q <= !rd_byte[7];
                  end
               end
            end
            ST_RD: begin
               if (scl_fall) begin
                  if (cnt_q == `IOEXP_BIT_LAST - 4'h1) begin
                     cnt_q <= 4'h0;
                     sda_low_q <= 1'b0;
                  end else begin
                     shreg_q <= {shreg_q[6:0], 1'b0};
                     sda_low_q <= !shreg_q[6];
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) nack_q <= sda_f;
               if (load_rd) begin
                  cmd_q <= rd_sel;
                  shreg_q <= rd_byte;
                  sda_low_q <= !rd_byte[7];
               end
            end
         endcase
      end
   end

   // Open-drain data line, released unless pulling low
   assign SDA_O = 1'b0;
   assign SDA_OE_N = !sda_low_q;

   // Device interrupt pin
   logic changed;
   assign changed = chg_a || chg_b; // RULE7
   assign INT_N_O = 1'b0;
   assign INT_N_OE_N = !changed; // RULE8

   // Avalon slave: one wait cycle, then the answer
   logic ack_q;
   logic [31:0] rdata_q;
   logic [`IOEXP_IRQ_W-1:0] irq_st_q;
   logic [`IOEXP_IRQ_W-1:0] irq_msk_q;
   logic changed_q;
   logic av_req;
   logic av_wr;
   logic sel_ctrl;
   logic sel_stat;
   logic sel_irq_st;
   logic sel_irq_msk;
   logic [31:0] stat_word;
   logic [31:0] av_rmux;
   logic [`IOEXP_IRQ_W-1:0] irq_set;
   logic [`IOEXP_IRQ_W-1:0] irq_clr;

   assign av_req = (AVS_READ || AVS_WRITE) && !ack_q;
   assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_q;
   assign av_wr = AVS_WRITE && ack_q && AVS_BYTEENABLE[0];
   assign sel_ctrl = AVS_ADDRESS == `IOEXP_REG_CTRL;
   assign sel_stat = AVS_ADDRESS == `IOEXP_REG_STAT;
   assign sel_irq_st = AVS_ADDRESS == `IOEXP_REG_IRQ_ST;
   assign sel_irq_msk = AVS_ADDRESS == `IOEXP_REG_IRQ_MSK;
   assign stat_word = {9'h000, my_addr, 8'(rdv_b ^ pol_b), 8'(rdv_a ^ pol_a)};
   assign av_rmux = sel_ctrl ? {31'h0, ctrl_en_q}
                  : sel_stat ? stat_word
                  : sel_irq_st ? {29'h0, irq_st_q}
                  : sel_irq_msk ? {29'h0, irq_msk_q}
                  : 32'h0;
   assign irq_set = {load_rd && (rd_sel == `IOEXP_CMD_IN_A || rd_sel == `IOEXP_CMD_IN_B),
                     wr_strobe,
                     changed && !changed_q};
   assign irq_clr = (av_wr && sel_irq_st) ? AVS_WRITEDATA[`IOEXP_IRQ_W-1:0] : '0;
   assign AVS_READDATA = rdata_q;
   assign IRQ = |(irq_st_q & irq_msk_q);

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0;
         ctrl_en_q <= `IOEXP_CTRL_RST;
         irq_st_q <= `IOEXP_IRQ_RST;
         irq_msk_q <= `IOEXP_IRQ_RST;
         changed_q <= 1'b0;
      end else begin
         ack_q <= av_req;
         if (av_req && AVS_READ) rdata_q <= av_rmux;
         if (av_wr && sel_ctrl) ctrl_en_q <= AVS_WRITEDATA[`IOEXP_CTRL_EN];
         if (av_wr && sel_irq_msk) irq_msk_q <= AVS_WRITEDATA[`IOEXP_IRQ_W-1:0];
         // Set beats a clear in the same cycle
         irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
         changed_q <= changed;
      end
   end
endmodule
`default_nettype wire

// file: common/ioexp_params.svh
// Constants for the sixteen-line two-wire I/O expander.
// Assumes inclusion by bare name from every file that needs it.
`ifndef IOEXP_PARAMS_SVH
`define IOEXP_PARAMS_SVH

// Timing
`define IOEXP_CLK_NS 25
`define IOEXP_SPIKE_NS 50
`define IOEXP_FILT_CYC ((`IOEXP_SPIKE_NS + `IOEXP_CLK_NS - 1) / `IOEXP_CLK_NS)

// Port geometry
`define IOEXP_PORT_W 8
`define IOEXP_BIT_LAST 4'h8

// Device register commands
`define IOEXP_CMD_IN_A 3'h0
`define IOEXP_CMD_IN_B 3'h1
`define IOEXP_CMD_OUT_A 3'h2
`define IOEXP_CMD_OUT_B 3'h3
`define IOEXP_CMD_POL_A 3'h4
`define IOEXP_CMD_POL_B 3'h5
`define IOEXP_CMD_CFG_A 3'h6
`define IOEXP_CMD_CFG_B 3'h7

// Device register reset values
`define IOEXP_OUT_RST 8'hFF
`define IOEXP_POL_RST 8'h00
`define IOEXP_CFG_RST 8'hFF

// Address pin strap codes
`define IOEXP_STRAP_GND 2'h0
`define IOEXP_STRAP_VDD 2'h1
`define IOEXP_STRAP_SDA 2'h2
`define IOEXP_STRAP_SCL 2'h3
`define IOEXP_ADDR_BASE 1'h1

// Avalon register byte offsets
`define IOEXP_REG_CTRL 4'h0
`define IOEXP_REG_STAT 4'h4
`define IOEXP_REG_IRQ_ST 4'h8
`define IOEXP_REG_IRQ_MSK 4'hC

// Field positions
`define IOEXP_CTRL_EN 0
`define IOEXP_CTRL_RST 1'h1
`define IOEXP_STAT_ADDR_LSB 16
`define IOEXP_IRQ_CHANGE 0
`define IOEXP_IRQ_WRITE 1
`define IOEXP_IRQ_INREAD 2
`define IOEXP_IRQ_W 3
`define IOEXP_IRQ_RST 3'h0

`endif

// file: common/ioexp_pkg.sv
// Types shared by the I/O expander modules.
// Assumes the parameter header is on the include path.
`default_nettype none
`include "ioexp_params.svh"
package ioexp_pkg;
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_ADDR = 8'h02,
      ST_ACKA = 8'h04,
      ST_CMD  = 8'h08,
      ST_ACKC = 8'h10,
      ST_WR   = 8'h20,
      ST_RD   = 8'h40,
      ST_RACK = 8'h80
   } ioexp_state_e;

   // Strap code of one address pin from three samples
   function automatic logic [1:0] ioexp_code(input logic pre, input logic st, input logic low);
      if (!st) begin
         ioexp_code = pre ? `IOEXP_STRAP_SDA : `IOEXP_STRAP_GND;
      end else begin
         ioexp_code = low ? `IOEXP_STRAP_VDD : `IOEXP_STRAP_SCL;
      end
   endfunction
endpackage
`default_nettype wire

// file: hdl/ioexp_filt.sv
// Spike filter for the serial and strap inputs.
// Assumes inputs already synchronous to clk.
`default_nettype none
`include "ioexp_params.svh"
module ioexp_filt
   import ioexp_pkg::*;
#(
   parameter int W = 5,
   parameter int CYC = `IOEXP_FILT_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] raw,
   output logic [W-1:0] filt
);
   logic [W-1:0][3:0] cnt_q;

   // Output follows only after CYC equal samples
   always_ff @(posedge clk) begin
      for (int i = 0; i < W; i++) begin
         if (!rst_n) begin
            filt[i] <= 1'b1;
            cnt_q[i] <= 4'h0;
         end else if (raw[i] == filt[i]) begin
            cnt_q[i] <= 4'h0;
         end else if (cnt_q[i] >= 4'(CYC - 1)) begin
            filt[i] <= raw[i];
            cnt_q[i] <= 4'h0;
         end else begin
            cnt_q[i] <= cnt_q[i] + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// file: hdl/ioexp_port.sv
// One eight-line port: output, polarity and direction registers,
// input sampling and change detection. Pins synchronous to clk.
`default_nettype none
`include "ioexp_params.svh"
module ioexp_port
   import ioexp_pkg::*;
#(
   parameter int W = `IOEXP_PORT_W,
   parameter bit OPEN_DRAIN = 1'b0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] pin_i,
   input wire logic [W-1:0] wdata,
   input wire logic wr_out,
   input wire logic wr_pol,
   input wire logic wr_cfg,
   input wire logic snap_ld,
   output logic [W-1:0] out_val,
   output logic [W-1:0] pol_val,
   output logic [W-1:0] cfg_val,
   output logic [W-1:0] rd_val,
   output logic [W-1:0] pin_o,
   output logic [W-1:0] pin_oe_n,
   output logic changed
);
   logic [W-1:0] pin_q;
   logic [W-1:0] snap_q;
   logic init_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         out_val <= W'(`IOEXP_OUT_RST);
         pol_val <= W'(`IOEXP_POL_RST);
         cfg_val <= W'(`IOEXP_CFG_RST); // RULE2
         pin_q <= '0;
         snap_q <= '0;
         init_q <= 1'b0;
      end else begin
         pin_q <= pin_i; // RULE4
         init_q <= 1'b1;
         if (wr_out) out_val <= wdata;
         if (wr_pol) pol_val <= wdata;
         if (wr_cfg) cfg_val <= wdata; // RULE3
         // Held value starts from the pins, not a blind zero
         if (snap_ld || !init_q) snap_q <= init_q ? pin_q : pin_i; // RULE14
      end
   end

   assign rd_val = pin_q ^ pol_val; // RULE5
   assign changed = init_q && |((pin_q ^ snap_q) & cfg_val); // RULE7
   // Direction bit high keeps the line released
   assign pin_o = OPEN_DRAIN ? '0 : out_val; // RULE4
   assign pin_oe_n = OPEN_DRAIN ? (cfg_val | out_val) : cfg_val; // RULE3 RULE13
endmodule
`default_nettype wire

// file: tb/igx_properties.sv
// Bound checker: bus handshake, reset values and pin relations.
// Assumes it is bound to ioexp_top and shares its clock and reset.
`default_nettype none
module igx_properties #(
   parameter int W = 8
) (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic SCL_I,
   input wire logic SDA_O,
   input wire logic SDA_OE_N,
   input wire logic [W-1:0] PORT_A_O,
   input wire logic [W-1:0] PORT_A_OE_N,
   input wire logic [W-1:0] PORT_B_O,
   input wire logic [W-1:0] PORT_B_OE_N,
   input wire logic INT_N_O,
   input wire logic INT_N_OE_N,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic IRQ
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_N);
   wire logic req = AVS_READ || AVS_WRITE;
   property p_rst_dirs;
      disable iff (1'b0) !RST_N |=> &{PORT_A_OE_N, PORT_B_OE_N, SDA_OE_N, INT_N_OE_N};
   endproperty
   a_rst_dirs: assert property (p_rst_dirs) else $error("line driven after reset");
   property p_rst_regs;
      disable iff (1'b0) !RST_N |=> &{PORT_A_O, PORT_B_O} && AVS_READDATA == 32'h0 && !IRQ;
   endproperty
   a_rst_regs: assert property (p_rst_regs) else $error("bad reset value");
   property p_int_pin;
      INT_N_O == 1'b0;
   endproperty
   a_int_pin: assert property (p_int_pin) else $error("interrupt pin drives high");
   property p_sda_od;
      SDA_O == 1'b0;
   endproperty
   a_sda_od: assert property (p_sda_od) else $error("data pin drives high");
   // Interrupt stays released while every line of both ports is driven
   property p_all_out;
      (PORT_A_OE_N == '0 && PORT_B_OE_N == '0) |-> INT_N_OE_N;
   endproperty
   a_all_out: assert property (p_all_out) else $error("interrupt with no inputs");
   property p_idle;
      !req |-> !AVS_WAITREQUEST;
   endproperty
   a_idle: assert property (p_idle) else $error("wait without request");
   property p_one_wait;
      req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("wait longer than one");
   property p_first_wait;
      $rose(AVS_READ) || $rose(AVS_WRITE) |-> AVS_WAITREQUEST;
   endproperty
   a_first_wait: assert property (p_first_wait) else $error("no wait cycle");
   // Data line may only move while the clock is low
   property p_sda_scl;
      !$stable(SDA_OE_N) |-> !SCL_I;
   endproperty
   a_sda_scl: assert property (p_sda_scl) else $error("data moved with clock high");
   c_ack: cover property (!SDA_OE_N);
   c_int: cover property (!INT_N_OE_N);
   c_irq: cover property (IRQ);
   c_rd: cover property (AVS_READ && !AVS_WAITREQUEST);
endmodule
bind ioexp_top igx_properties #(.W(W)) u_igx_properties (
   .CORE_CLK, .RST_N, .SCL_I, .SDA_O, .SDA_OE_N, .PORT_A_O, .PORT_A_OE_N, .PORT_B_O,
   .PORT_B_OE_N, .INT_N_O, .INT_N_OE_N, .AVS_READ, .AVS_WRITE, .AVS_READDATA,
   .AVS_WAITREQUEST, .IRQ
);
`default_nettype wire

// file: tb/igx_mst.sv
// Two-wire bus master model for the expander's serial side.
// Assumes the bench resolves the open-drain data line with a pull-up.
`default_nettype none
module igx_mst (
   input wire logic clk,
   input wire logic sda_in,
   output logic scl = 1'b1,
   output logic sda = 1'b1
);
   timeunit 1ns;
   timeprecision 100ps;
   // Twenty-cycle halves: 1 MHz, the top allowed rate
   localparam int HALF = 20;
   // Data set well after the fall, past the slave's hold
   localparam int SETUP = 6;
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic bit_io(input logic b, output logic r);
      tick(SETUP);
      sda <= b;
      tick(HALF - SETUP);
      scl <= 1'b1;
      tick(HALF);
      r = sda_in;
      scl <= 1'b0;
   endtask
   task automatic start();
      tick(SETUP);
      sda <= 1'b1;
      tick(HALF - SETUP);
      scl <= 1'b1;
      tick(HALF);
      sda <= 1'b0;
      tick(HALF);
      scl <= 1'b0;
   endtask
   task automatic stop();
      tick(SETUP);
      sda <= 1'b0;
      tick(HALF - SETUP);
      scl <= 1'b1;
      tick(HALF);
      sda <= 1'b1;
      tick(HALF);
   endtask
   task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic wr_reg(input logic [6:0] a, input logic [2:0] c, input logic [7:0] d,
                         output logic ok);
      logic [7:0] q;
      logic k0, k1, k2;
      start();
      xfer({a, 1'b0}, q, k0);
      xfer({5'h00, c}, q, k1);
      xfer(d, q, k2);
      stop();
      ok = k0 & k1 & k2;
   endtask
   // Single byte read, ended by a NACK
   task automatic rd_reg(input logic [6:0] a, input logic [2:0] c, output logic [7:0] d,
                         output logic ok);
      logic [7:0] q;
      logic k0, k1, k2, nk;
      start();
      xfer({a, 1'b0}, q, k0);
      xfer({5'h00, c}, q, k1);
      start();
      xfer({a, 1'b1}, q, k2);
      xfer(8'hFF, d, nk);
      stop();
      ok = k0 & k1 & k2;
   endtask
endmodule
`default_nettype wire

// file: tb/i2c_gpio_expander_16bit_tb_top.sv
// Self-checking bench: serial master model, Avalon master, pin models.
// Assumes the bound checker and default filter length.
`default_nettype none
`include "ioexp_params.svh"
module i2c_gpio_expander_16bit_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic ok;
   logic [3:0] aa = 4'h0;
   logic [31:0] wd = 32'h0;
   logic [31:0] q, res_v;
   logic [1:0] strap [3] = '{2'h0, 2'h1, 2'h0};
   logic [7:0] cfg [2], outr [2], pol [2], ext [2], v;
   logic [31:0] exp_q [$];
   int seed = 32'h07E613A3;
   int n_checks = 0;
   int err_count = 0;
   int cyc = 0;
   event res_ev;
   wire logic [7:0] pa_o, pa_oe, pb_o, pb_oe;
   wire logic sda_o, sda_oe, int_o, int_oe, irq, wt, scl, sda_m;
   wire logic [31:0] rdata;
   wire logic sda = sda_m & (sda_oe | sda_o);
   wire logic [3:0] lv = {scl, sda, 2'b10};
   wire logic [6:0] addr = {1'b1, strap[2], strap[1], strap[0]};
   wire logic [7:0] pa_i = ~pa_oe & pa_o | pa_oe & ext[0];
   wire logic [7:0] pb_i = ~pb_oe & pb_o | pb_oe & ext[1];
   initial forever #12.5 clk = ~clk;
   ioexp_top u_ioexp_top (
      .CORE_CLK(clk), .RST_N(rst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
      .SDA_OE_N(sda_oe), .ADDR_SELECT_0(lv[strap[0]]), .ADDR_SELECT_1(lv[strap[1]]),
      .ADDR_SELECT_2(lv[strap[2]]), .PORT_A_I(pa_i), .PORT_A_O(pa_o), .PORT_A_OE_N(pa_oe),
      .PORT_B_I(pb_i), .PORT_B_O(pb_o), .PORT_B_OE_N(pb_oe), .INT_N_O(int_o),
      .INT_N_OE_N(int_oe), .AVS_ADDRESS(aa), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(wt), .IRQ(irq)
   );
   igx_mst u_igx_mst (.clk(clk), .sda_in(sda), .scl(scl), .sda(sda_m));
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      n_checks++;
      if (got !== want) begin
         err_count++;
         $display("MISMATCH %0t got %h want %h", $time, got, want);
      end
   endtask
   // Watcher pairs each result with the oldest expectation
   initial forever begin
      @(res_ev);
      chk(res_v, exp_q.size() > 0 ? exp_q.pop_front() : ~res_v);
   end
   task automatic seen(input logic [31:0] s);
      res_v = s;
      ->res_ev;
      @(posedge clk);
   endtask
   task automatic ns(input logic [31:0] e, input logic [31:0] s);
      exp_q.push_back(e);
      seen(s);
   endtask
   task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] d);
      rd <= !w;
      wr <= w;
      aa <= a;
      wd <= d;
      do @(posedge clk); while (wt !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic avr(input logic [3:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      avs(1'b0, a, 32'h0);
      seen(q);
   endtask
   task automatic i2w(input logic [2:0] c, input logic [7:0] d);
      exp_q.push_back(32'h1);
      u_igx_mst.wr_reg(addr, c, d, ok);
      seen(32'(ok));
   endtask
   task automatic i2r(input logic [2:0] c, input logic [7:0] e);
      exp_q.push_back({23'h0, 1'b1, e});
      u_igx_mst.rd_reg(addr, c, v, ok);
      seen({23'h0, ok, v});
   endtask
   function automatic logic [7:0] pin(input int p);
      pin = ~cfg[p] & outr[p] | cfg[p] & ext[p];
   endfunction
   always @(posedge clk) begin
      cyc++;
      if (cyc == 70000) begin
         err_count++;
         wrap_up();
      end
   end
   initial begin
      for (int p = 0; p < 2; p++) begin
         cfg[p] = 8'hFF;
         outr[p] = 8'hFF;
         pol[p] = 8'h00;
         ext[p] = 8'($random(seed));
      end
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      ns(32'hFF, 32'(pa_oe));
      ns(32'hFF, 32'(pb_oe));
      ns(32'hFF, 32'(pb_o));
      ns(32'h1, 32'(int_oe));
      avr(`IOEXP_REG_CTRL, 32'h1);
      avr(`IOEXP_REG_IRQ_MSK, 32'h0);
      avs(1'b1, 4'h2, 32'hFFFFFFFF);
      avr(4'h2, 32'h0);
      i2r(`IOEXP_CMD_CFG_B, `IOEXP_CFG_RST);
      i2r(`IOEXP_CMD_OUT_B, `IOEXP_OUT_RST);
      i2r(`IOEXP_CMD_POL_B, `IOEXP_POL_RST);
      for (int k = 0; k < 4; k++) begin
         strap[0] <= 2'(k);
         strap[1] <= 2'(3 - k);
         strap[2] <= 2'(k) ^ 2'h1;
         cfg[0] = 8'($random(seed));
         @(posedge clk);
         i2w(`IOEXP_CMD_CFG_A, cfg[0]);
         i2r(`IOEXP_CMD_CFG_A, cfg[0]);
         avr(`IOEXP_REG_STAT, {9'h0, addr, pin(1), pin(0)});
      end
      for (int j = 0; j < 2; j++) begin
         avs(1'b1, `IOEXP_REG_CTRL, 32'(j));
         exp_q.push_back(32'h0);
         u_igx_mst.wr_reg(addr ^ 7'(j), `IOEXP_CMD_CFG_A, 8'h00, ok);
         seen(32'(ok));
      end
      i2r(`IOEXP_CMD_CFG_A, cfg[0]);
      for (int p = 0; p < 2; p++) begin
         cfg[p] = 8'($random(seed));
         outr[p] = 8'($random(seed));
         pol[p] = 8'($random(seed));
         ext[p] <= 8'($random(seed));
         i2w(3'(`IOEXP_CMD_CFG_A + p), cfg[p]);
         i2w(3'(`IOEXP_CMD_OUT_A + p), outr[p]);
         i2w(3'(`IOEXP_CMD_POL_A + p), pol[p]);
         ns(32'(cfg[p]), 32'(p ? pb_oe : pa_oe));
         ns(32'(outr[p]), 32'(p ? pb_o : pa_o));
         i2r(3'(`IOEXP_CMD_OUT_A + p), outr[p]);
         i2r(3'(`IOEXP_CMD_POL_A + p), pol[p]);
         i2r(3'(`IOEXP_CMD_IN_A + p), pin(p) ^ pol[p]);
      end
      i2w(`IOEXP_CMD_CFG_A, 8'h00);
      i2w(`IOEXP_CMD_CFG_B, 8'h00);
      cfg[0] = 8'h00;
      cfg[1] = 8'h00;
      ext[0] <= ~ext[0];
      ext[1] <= ~ext[1];
      repeat (8) @(posedge clk);
      ns(32'h1, 32'(int_oe));
      cfg[0] = 8'hFF;
      i2w(`IOEXP_CMD_CFG_A, 8'hFF);
      i2r(`IOEXP_CMD_IN_A, pin(0) ^ pol[0]);
      avs(1'b1, `IOEXP_REG_IRQ_ST, 32'h7);
      avr(`IOEXP_REG_IRQ_ST, 32'h0);
      avs(1'b1, `IOEXP_REG_IRQ_MSK, 32'h1);
      ext[0] <= ext[0] ^ 8'h81;
      for (int i = 0; i < 40 && irq !== 1'b1; i++) @(posedge clk);
      ns(32'h0, 32'(int_oe));
      ns(32'h1, 32'(irq));
      avr(`IOEXP_REG_IRQ_ST, 32'h1);
      i2r(`IOEXP_CMD_IN_A, pin(0) ^ pol[0]);
      ns(32'h1, 32'(int_oe));
      avs(1'b1, `IOEXP_REG_IRQ_ST, 32'h1);
      avr(`IOEXP_REG_IRQ_ST, 32'h4);
      ns(32'h0, 32'(irq));
      wrap_up();
   end
endmodule
`default_nettype wire
